// File: src/channel_pd_extra_lane_ctrl.sv
// apb register bank for converter power-down and link A extra lanes
// assumes pclk at 50 MHz, mode lane needs supplied by the link logic
`timescale 1ns/1ps
module channel_pd_extra_lane_ctrl #(
  parameter int NUM_LANES = 8,
  parameter int NUM_DIG = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_LANES-1:0] mode_lane_need,
  input wire logic mode_ab_on_link_a,
  output logic conv_a_powerdown,
  output logic conv_b_powerdown,
  output logic [NUM_DIG-1:0] dig_ch_powerdown,
  output logic link_subsys_powerdown,
  output logic serial_link_enable,
  output logic [4:0] link_mode_select,
  output logic [3:0] test_pattern_select,
  output logic [NUM_LANES-1:0] lane_clk_en,
  output logic [NUM_LANES-1:0] lane_ser_en,
  output logic [NUM_LANES-1:0] lane_ramp_en,
  output logic b_samples_undefined
);

  // ***************************
  // state
  // ***************************
  typedef struct packed {
    logic [7:0] ch_pd;
    logic [7:0] extra_a;
    logic link_en;
    logic [NUM_DIG-1:0] bind_b;
    logic [3:0] test;
    logic [4:0] mode;
    logic order_err;
    logic [31:0] rdata;
    logic ready;
    logic slverr;
    logic conv_a;
    logic conv_b;
    logic [NUM_DIG-1:0] dig;
    logic subsys;
    logic [NUM_LANES-1:0] clk_en;
    logic [NUM_LANES-1:0] ser_en;
    logic [NUM_LANES-1:0] ramp;
    logic b_undef;
    logic [3:0] test_q;
  } state_t;

  state_t s_reg;
  state_t s_next;

  logic c_conv_a;
  logic c_conv_b;
  logic [NUM_DIG-1:0] c_dig;
  logic c_subsys;
  logic [NUM_LANES-1:0] c_clk;
  logic [NUM_LANES-1:0] c_ser;
  logic [NUM_LANES-1:0] c_ramp;
  logic [NUM_LANES-1:0] extra_lanes;
  logic setup;
  logic access;
  logic wr_pd_ext;
  pd_lane_pkg::reg_sel_t sel;

  // every check below runs on pclk and is muted while reset is low
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ***************************
  // derived control
  // ***************************
  pd_map #(.NUM_DIG(NUM_DIG)) u_pd_map (
    .pd_a(s_reg.ch_pd[pd_lane_pkg::PD_A_BIT]),
    .pd_b(s_reg.ch_pd[pd_lane_pkg::PD_B_BIT]),
    .bind_b(s_reg.bind_b),
    .conv_a(c_conv_a),
    .conv_b(c_conv_b),
    .dig_pd(c_dig),
    .subsys_pd(c_subsys)
  );

  // lane 0 has no extra bit: bit 0 is the serializer option
  assign extra_lanes = {s_reg.extra_a[NUM_LANES-1:1], 1'b0};

  lane_enable_calc #(.NUM_LANES(NUM_LANES)) u_lanes (
    .link_active(s_reg.link_en & ~c_subsys),
    .mode_need(mode_lane_need),
    .extra(extra_lanes),
    .ser_opt(s_reg.extra_a[pd_lane_pkg::SER_OPT_BIT]),
    .test(s_reg.test),
    .clk_en(c_clk),
    .ser_en(c_ser),
    .ramp(c_ramp)
  );

  // ***************************
  // apb and register update
  // ***************************
  assign setup = psel & ~penable;
  assign access = psel & penable & s_reg.ready;
  assign sel = pd_lane_pkg::decode(paddr);
  // changing these while the link runs is a software slip; it is kept
  assign wr_pd_ext = access & pwrite & pstrb[0] & s_reg.link_en &
                     ((sel == pd_lane_pkg::SEL_CH_PD) ||
                      (sel == pd_lane_pkg::SEL_EXTRA));

  always_comb begin
    s_next = s_reg;
    s_next.ready = setup;
    if (setup) begin
      s_next.slverr = (sel == pd_lane_pkg::SEL_NONE);
      s_next.rdata = 32'h0000_0000;
      unique case (sel)
        pd_lane_pkg::SEL_CH_PD: s_next.rdata[7:0] = s_reg.ch_pd;
        pd_lane_pkg::SEL_EXTRA: s_next.rdata[7:0] = s_reg.extra_a;
        pd_lane_pkg::SEL_CFG: begin
          s_next.rdata[pd_lane_pkg::CFG_EN_BIT] = s_reg.link_en;
          s_next.rdata[pd_lane_pkg::CFG_BIND_LSB +: NUM_DIG] = s_reg.bind_b;
          s_next.rdata[pd_lane_pkg::CFG_TEST_LSB +: 4] = s_reg.test;
          s_next.rdata[pd_lane_pkg::CFG_MODE_LSB +: 5] = s_reg.mode;
        end
        pd_lane_pkg::SEL_STAT: begin
          s_next.rdata[pd_lane_pkg::ST_CONV_A] = s_reg.conv_a;
          s_next.rdata[pd_lane_pkg::ST_CONV_B] = s_reg.conv_b;
          s_next.rdata[pd_lane_pkg::ST_SUBSYS] = s_reg.subsys;
          s_next.rdata[pd_lane_pkg::ST_B_UNDEF] = s_reg.b_undef;
          s_next.rdata[pd_lane_pkg::ST_ORDER_ERR] = s_reg.order_err;
          s_next.rdata[pd_lane_pkg::ST_CLK_LSB +: NUM_LANES] = s_reg.clk_en;
          s_next.rdata[pd_lane_pkg::ST_SER_LSB +: NUM_LANES] = s_reg.ser_en;
        end
        pd_lane_pkg::SEL_NONE: s_next.rdata = 32'h0000_0000;
      endcase
    end else if (!psel) begin
      s_next.slverr = 1'b0;
    end
    if (access && pwrite) begin
      unique case (sel)
        pd_lane_pkg::SEL_CH_PD:
          if (pstrb[0]) s_next.ch_pd = pwdata[7:0];
        pd_lane_pkg::SEL_EXTRA:
          if (pstrb[0]) s_next.extra_a = pwdata[7:0];
        pd_lane_pkg::SEL_CFG: begin
          if (pstrb[0]) begin
            s_next.link_en = pwdata[pd_lane_pkg::CFG_EN_BIT];
            s_next.bind_b = pwdata[pd_lane_pkg::CFG_BIND_LSB +: NUM_DIG];
            s_next.test = pwdata[pd_lane_pkg::CFG_TEST_LSB +: 4];
          end
          if (pstrb[1]) begin
            s_next.mode = pwdata[pd_lane_pkg::CFG_MODE_LSB +: 5];
          end
        end
        pd_lane_pkg::SEL_STAT:
          if (pstrb[0] && pwdata[pd_lane_pkg::ST_ORDER_ERR]) begin
            s_next.order_err = 1'b0;
          end
        pd_lane_pkg::SEL_NONE: s_next.order_err = s_reg.order_err;
      endcase
    end
    // a new slip beats a clear in the same cycle
    if (wr_pd_ext) begin
      s_next.order_err = 1'b1;
    end
    s_next.conv_a = c_conv_a;
    s_next.conv_b = c_conv_b;
    s_next.dig = c_dig;
    s_next.subsys = c_subsys;
    s_next.clk_en = c_clk;
    s_next.ser_en = c_ser;
    s_next.ramp = c_ramp;
    s_next.test_q = s_reg.test;
    // link A stays up; only the B sample content is lost
    s_next.b_undef = mode_ab_on_link_a &
                     s_reg.ch_pd[pd_lane_pkg::PD_B_BIT] & ~c_subsys;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
      s_reg.ch_pd <= pd_lane_pkg::CH_PD_RST;
      s_reg.extra_a <= pd_lane_pkg::EXTRA_A_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // ***************************
  // outputs
  // ***************************
  assign prdata = s_reg.rdata;
  assign pready = s_reg.ready;
  assign pslverr = s_reg.slverr;
  assign conv_a_powerdown = s_reg.conv_a;
  assign conv_b_powerdown = s_reg.conv_b;
  assign dig_ch_powerdown = s_reg.dig;
  assign link_subsys_powerdown = s_reg.subsys;
  assign serial_link_enable = s_reg.link_en;
  assign link_mode_select = s_reg.mode;
  assign test_pattern_select = s_reg.test_q;
  assign lane_clk_en = s_reg.clk_en;
  assign lane_ser_en = s_reg.ser_en;
  assign lane_ramp_en = s_reg.ramp;
  assign b_samples_undefined = s_reg.b_undef;

  // ***************************
  // assertions
  // ***************************
  a_ready_after_setup: assert property (
    setup |=> pready ##1 !pready) else $error("pready not one cycle");

  a_conv_b_follows: assert property (
    s_reg.ch_pd[1] |=> conv_b_powerdown)
    else $error("channel B not powered down");

  a_conv_a_follows: assert property (
    !s_reg.ch_pd[0] |=> !conv_a_powerdown)
    else $error("channel A powered down while bit clear");

  a_dig_binding: assert property (
    (s_reg.bind_b[0] ? s_reg.ch_pd[1] : s_reg.ch_pd[0])
    |=> dig_ch_powerdown[0])
    else $error("bound digital channel left powered");

  a_subsys_both: assert property (
    (s_reg.ch_pd[1:0] == 2'h3) |=> link_subsys_powerdown ##0
    (lane_clk_en == '0)) else $error("subsystem not powered down");

  a_b_undef_link: assert property (
    (mode_ab_on_link_a && s_reg.ch_pd[1:0] == 2'h2)
    |=> b_samples_undefined && !link_subsys_powerdown)
    else $error("link A not kept for B undefined case");

  a_extra_clk: assert property (
    (s_reg.link_en && s_reg.ch_pd[1:0] != 2'h3 && s_reg.extra_a[1])
    |=> lane_clk_en[1]) else $error("extra lane clock missing");

  a_ser_opt_off: assert property (
    (!s_reg.extra_a[0] && !mode_lane_need[1]) |=> !lane_ser_en[1])
    else $error("serializer on without option");

  a_ser_opt_on: assert property (
    (s_reg.link_en && s_reg.ch_pd[1:0] != 2'h3 && s_reg.extra_a[1:0] ==
     2'h3 && mode_lane_need[0]) |=> lane_ser_en[1])
    else $error("serializer option ignored");

  a_ramp_pattern: assert property (
    lane_ramp_en[1] |-> ($past(s_reg.test) == 4'h0 ||
    $past(s_reg.test) == 4'h5)) else $error("ramp with wrong pattern");

  a_down_no_lane: assert property (
    link_subsys_powerdown |-> (lane_ser_en == '0))
    else $error("lane active on powered-down link");

  a_ser_chain: assert property (
    lane_ser_en[2] |-> (lane_ser_en[1:0] == 2'h3))
    else $error("serializer clocked above a gap");

  a_pd_write: assert property (
    (access && pwrite && pstrb[0] && sel == pd_lane_pkg::SEL_CH_PD)
    |=> s_reg.ch_pd == $past(pwdata[7:0]))
    else $error("power-down write lost");

  a_order_flag: assert property (
    wr_pd_ext |=> s_reg.order_err) else $error("order slip not flagged");

  a_order_clear: assert property (
    (access && pwrite && pstrb[0] && sel == pd_lane_pkg::SEL_STAT &&
     pwdata[pd_lane_pkg::ST_ORDER_ERR]) |=> !s_reg.order_err)
    else $error("order flag not cleared");

  a_slverr_unmapped: assert property (
    (setup && sel == pd_lane_pkg::SEL_NONE) |=> pready && pslverr)
    else $error("unmapped access not refused");

  a_subsys_only_both: assert property (
    (s_reg.ch_pd[1:0] != 2'h3) |=> !link_subsys_powerdown)
    else $error("subsystem down with a converter on");

  a_digital_channel_binding_high: assert property (
    (s_reg.bind_b[1] ? s_reg.ch_pd[1] : s_reg.ch_pd[0])
    |=> dig_ch_powerdown[1])
    else $error("bound digital channel 1 left powered");

  a_test_follows: assert property (
    (s_reg.test == pd_lane_pkg::TEST_RAMP)
    |=> (test_pattern_select == pd_lane_pkg::TEST_RAMP))
    else $error("test pattern not passed on");

  // a serializer without its lane clocks would shift garbage
  a_clk_covers_ser: assert property (
    (lane_ser_en & ~lane_clk_en) == '0)
    else $error("serializer on without lane clocks");

  a_chain_top: assert property (
    lane_ser_en[NUM_LANES-1] |-> (&lane_ser_en[NUM_LANES-2:0]))
    else $error("top serializer clocked above a gap");

endmodule : channel_pd_extra_lane_ctrl

// File: inc/pd_lane_pkg.sv
// constants, field layout and register map of the channel power-down and
// extra-lane block; assumes APB access with one aligned word per register
//
// Function
// - setting the B power-down bit powers down converter channel B
// - setting the A power-down bit powers down converter channel A
// - a powered-down converter also powers down its bound digital channels
// - both converters down powers down the whole serial-link subsystem
// - B digital channel off on shared link A: link A runs, B undefined
// - extra-lane bits 7:1 enable lanes 1 to 7 of link A
// - an extra-lane bit alone turns on only the lane's link-layer clocks
// - bit 0 low gives clocks only; high also enables extra serializers
// - extra lanes take rate and mode from link mode and test pattern
// - extra-only lane with test pattern 0 or 5 sends the octet ramp
// - extra-lane bits never override a powered-down link
// - serializer n gets a clock only if lanes 0 to n-1 are enabled
// - power-down register at index 0x209 resets to 0x00
package pd_lane_pkg;

  // ***************************
  // register indices and addresses
  // ***************************
  localparam int ADDR_W = 12;
  localparam logic [9:0] IDX_CH_PD = 10'h209;
  localparam logic [9:0] IDX_EXTRA_A = 10'h20A;
  localparam logic [9:0] IDX_LINK_CFG = 10'h20C;
  localparam logic [9:0] IDX_STATUS = 10'h20D;
  localparam logic [11:0] ADDR_CH_PD = {IDX_CH_PD, 2'h0};
  localparam logic [11:0] ADDR_EXTRA_A = {IDX_EXTRA_A, 2'h0};
  localparam logic [11:0] ADDR_LINK_CFG = {IDX_LINK_CFG, 2'h0};
  localparam logic [11:0] ADDR_STATUS = {IDX_STATUS, 2'h0};

  // ***************************
  // reset values
  // ***************************
  localparam logic [7:0] CH_PD_RST = 8'h00;
  localparam logic [7:0] EXTRA_A_RST = 8'h00;

  // ***************************
  // fields
  // ***************************
  localparam int PD_A_BIT = 0;
  localparam int PD_B_BIT = 1;
  localparam int SER_OPT_BIT = 0;
  localparam int CFG_EN_BIT = 0;
  localparam int CFG_BIND_LSB = 1;
  localparam int CFG_TEST_LSB = 4;
  localparam int CFG_MODE_LSB = 8;
  localparam int TEST_W = 4;
  localparam int MODE_W = 5;
  localparam int ST_CONV_A = 0;
  localparam int ST_CONV_B = 1;
  localparam int ST_SUBSYS = 2;
  localparam int ST_B_UNDEF = 3;
  localparam int ST_ORDER_ERR = 4;
  localparam int ST_CLK_LSB = 8;
  localparam int ST_SER_LSB = 16;
  localparam logic [3:0] TEST_NONE = 4'h0;
  localparam logic [3:0] TEST_RAMP = 4'h4;
  localparam logic [3:0] TEST_ALT = 4'h5;

  typedef enum logic [2:0] {
    SEL_NONE = 3'h0,
    SEL_CH_PD = 3'h1,
    SEL_EXTRA = 3'h2,
    SEL_CFG = 3'h3,
    SEL_STAT = 3'h4
  } reg_sel_t;

  function automatic reg_sel_t decode(input logic [11:0] a);
    unique case (a)
      ADDR_CH_PD: decode = SEL_CH_PD;
      ADDR_EXTRA_A: decode = SEL_EXTRA;
      ADDR_LINK_CFG: decode = SEL_CFG;
      ADDR_STATUS: decode = SEL_STAT;
      default: decode = SEL_NONE;
    endcase
  endfunction : decode

endpackage : pd_lane_pkg

// File: src/pd_map.sv
// power-down fan-out from the converter bits to digital channels and link
// assumes binding bit i low ties digital channel i to converter A
`timescale 1ns/1ps
module pd_map #(
  parameter int NUM_DIG = 2
) (
  input wire logic pd_a,
  input wire logic pd_b,
  input wire logic [NUM_DIG-1:0] bind_b,
  output logic conv_a,
  output logic conv_b,
  output logic [NUM_DIG-1:0] dig_pd,
  output logic subsys_pd
);

  always_comb begin
    conv_a = pd_a;
    conv_b = pd_b;
    // a channel bound to B falls with B, others with A
    for (int i = 0; i < NUM_DIG; i++) begin
      dig_pd[i] = bind_b[i] ? pd_b : pd_a;
    end
    subsys_pd = pd_a & pd_b;
  end

endmodule : pd_map

// File: src/lane_enable_calc.sv
// per-lane clock, serializer and ramp enables of link A
// assumes mode_need comes from the link-mode logic outside this block
`timescale 1ns/1ps
module lane_enable_calc #(
  parameter int NUM_LANES = 8
) (
  input wire logic link_active,
  input wire logic [NUM_LANES-1:0] mode_need,
  input wire logic [NUM_LANES-1:0] extra,
  input wire logic ser_opt,
  input wire logic [3:0] test,
  output logic [NUM_LANES-1:0] clk_en,
  output logic [NUM_LANES-1:0] ser_en,
  output logic [NUM_LANES-1:0] ramp
);

  logic chain;
  logic ramp_ok;
  logic [NUM_LANES-1:0] want;

  always_comb begin
    chain = 1'b1;
    ramp_ok = (test == pd_lane_pkg::TEST_NONE) ||
              (test == pd_lane_pkg::TEST_ALT);
    for (int n = 0; n < NUM_LANES; n++) begin
      // a dead link keeps every lane off
      clk_en[n] = link_active & (mode_need[n] | extra[n]);
      want[n] = link_active & (mode_need[n] | (extra[n] & ser_opt));
      // no clock reaches a serializer above a gap
      ser_en[n] = want[n] & chain;
      chain = chain & want[n];
      // rate and mode follow the link; only the pattern may change
      ramp[n] = ser_en[n] & extra[n] & ~mode_need[n] & ramp_ok;
    end
  end

endmodule : lane_enable_calc

// File: verification/channel_pd_extra_lane_ctrl_bench.sv
// self-checking bench for the power-down and extra-lane register bank
// assumes the apb timing and register layout of the designer's hand-over
`timescale 1ns/1ps
module channel_pd_extra_lane_ctrl_bench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic [7:0] need = 8'h01;
  logic ab_on_a = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, pd_a, pd_b, subsys, link_en, b_undef;
  logic [1:0] dig;
  logic [4:0] mode_o;
  logic [3:0] test_o;
  logic [7:0] clk_en, ser_en, ramp_en;
  logic [1:0] bind_g = 2'h0;
  logic [3:0] test_g = 4'h0;
  logic [4:0] mode_g = 5'h13;
  int errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [3:0] tv [4] = '{4'h0, 4'h5, 4'h4, 4'h3};

  channel_pd_extra_lane_ctrl u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mode_lane_need(need), .mode_ab_on_link_a(ab_on_a),
    .conv_a_powerdown(pd_a), .conv_b_powerdown(pd_b),
    .dig_ch_powerdown(dig), .link_subsys_powerdown(subsys),
    .serial_link_enable(link_en), .link_mode_select(mode_o),
    .test_pattern_select(test_o), .lane_clk_en(clk_en),
    .lane_ser_en(ser_en), .lane_ramp_en(ramp_en),
    .b_samples_undefined(b_undef)
  );

  always #10 pclk = ~pclk;

  // ***************************
  // helpers
  // ***************************
  task automatic summarize();
    if (errors == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize

  // a hang is cut short here rather than by the simulator
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      $display("ERROR %0t timeout", $time);
      summarize();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string msg);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge pclk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) chk(32'h1, 32'h0, "no pready");
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
    chk({31'h0, e}, 32'h0, "write slverr");
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] exp,
                    input logic experr);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, exp, "read data");
    chk({31'h0, e}, {31'h0, experr}, "read slverr");
  endtask : rd

  task automatic cfg(input logic en);
    wr(pd_lane_pkg::ADDR_LINK_CFG,
       {19'h0, mode_g, test_g, 1'b0, bind_g, en});
  endtask : cfg

  // link enable dropped around every change, as software must do
  task automatic safe_wr(input logic [11:0] a, input logic [7:0] v);
    cfg(1'b0);
    wr(a, {24'h0, v});
    cfg(1'b1);
  endtask : safe_wr

  task automatic conv(input logic a, input logic b, input logic [1:0] dg,
                      input logic sb, input logic bu);
    repeat (3) @(posedge pclk);
    chk({26'h0, pd_a, pd_b, dig, subsys, b_undef},
        {26'h0, a, b, dg, sb, bu}, "converter power-down");
  endtask : conv

  task automatic lanes(input logic [7:0] c, input logic [7:0] s,
                       input logic [7:0] r);
    repeat (3) @(posedge pclk);
    chk({8'h0, clk_en, ser_en, ramp_en}, {8'h0, c, s, r}, "lane enables");
  endtask : lanes

  task automatic do_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
  endtask : do_reset

  // ***************************
  // main sequence
  // ***************************
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(pd_lane_pkg::ADDR_CH_PD, 32'h0, 1'b0);
    rd(pd_lane_pkg::ADDR_EXTRA_A, 32'h0, 1'b0);
    conv(1'b0, 1'b0, 2'b00, 1'b0, 1'b0);
    rd(12'h000, 32'h0, 1'b1);
    cfg(1'b0);
    wr(pd_lane_pkg::ADDR_CH_PD, 32'h01);
    conv(1'b1, 1'b0, 2'b11, 1'b0, 1'b0);
    bind_g = 2'b10;
    cfg(1'b0);
    ab_on_a <= 1'b1;
    wr(pd_lane_pkg::ADDR_CH_PD, 32'h02);
    conv(1'b0, 1'b1, 2'b10, 1'b0, 1'b1);
    // both-down through the operating mode and the calibration field
    // sit outside this block; both bits are set here only to reach
    wr(pd_lane_pkg::ADDR_CH_PD, 32'hFF);
    rd(pd_lane_pkg::ADDR_CH_PD, 32'hFF, 1'b0);
    conv(1'b1, 1'b1, 2'b11, 1'b1, 1'b0);
    wr(pd_lane_pkg::ADDR_EXTRA_A, 32'hFF);
    cfg(1'b1);
    lanes(8'h00, 8'h00, 8'h00);
    cfg(1'b0);
    wr(pd_lane_pkg::ADDR_CH_PD, 32'h00);
    // selector values 0, 5, 4 and 3: only 0 and 5 turn extra-only lanes to ramp
    for (int i = 0; i < 4; i++) begin
      test_g = tv[i];
      cfg(1'b1);
      lanes(8'hFF, 8'hFF, (tv[i] == 4'h0 || tv[i] == 4'h5) ?
            8'hFE : 8'h00);
      chk({11'h0, mode_o, test_o, 12'h0},
          {11'h0, mode_g, tv[i], 12'h0}, "mode and test");
    end
    test_g = 4'h0;
    safe_wr(pd_lane_pkg::ADDR_EXTRA_A, 8'hFE);
    lanes(8'hFF, 8'h01, 8'h00);
    safe_wr(pd_lane_pkg::ADDR_EXTRA_A, 8'hF7);
    lanes(8'hF7, 8'h07, 8'h06);
    need <= 8'h0F;
    lanes(8'hFF, 8'hFF, 8'hF0);
    // deliberate slip with the link running: the order flag must catch it
    rd(pd_lane_pkg::ADDR_STATUS, 32'h00FF_FF00, 1'b0);
    wr(pd_lane_pkg::ADDR_EXTRA_A, 32'hF7);
    rd(pd_lane_pkg::ADDR_STATUS, 32'h00FF_FF10, 1'b0);
    wr(pd_lane_pkg::ADDR_STATUS, 32'h10);
    rd(pd_lane_pkg::ADDR_STATUS, 32'h00FF_FF00, 1'b0);
    cfg(1'b0);
    lanes(8'h00, 8'h00, 8'h00);
    // second reset in mid-run must clear the extra-lane, power-down and status registers again
    do_reset();
    rd(pd_lane_pkg::ADDR_EXTRA_A, 32'h0, 1'b0);
    rd(pd_lane_pkg::ADDR_CH_PD, 32'h0, 1'b0);
    rd(pd_lane_pkg::ADDR_STATUS, 32'h0, 1'b0);
    conv(1'b0, 1'b0, 2'b00, 1'b0, 1'b0);
    summarize();
  end
endmodule : channel_pd_extra_lane_ctrl_bench
